// >>> periph_select_pkg.sv
// constants and carrier types for the on-chip peripheral select decode
// Behaviour
// - timekeeper enabled routes its address window to the on-chip timekeeper.
// - both CAN disabled sends 00'EE00h-00'EFFFh accesses to external memory.
// - second CAN disabled releases port-4 bits 4 and 7 as general I/O.
// - first CAN disabled releases port-4 bits 5 and 6 as general I/O.
// - reset enables first CAN and small RAM, disables second CAN and large RAM.
// - after the global peripheral enable is set the selection cannot change.
// - emulation mode treats every extension peripheral as enabled.
// - timekeeper disabled stops the oscillator in power-down.
// - timekeeper enabled lets the power-down choice bit decide the oscillator.
// - small RAM disabled sends 00'E000h-00'E7FFh to external memory, else internal.
// - large RAM disabled sends 00'C000h-00'DFFFh to external memory, else internal.
// - CAN windows EF00h/EE00h go external only when both CAN enables are 0.
// - timekeeper window goes external only when it and both CANs are disabled.
package periph_select_pkg;

  localparam logic [7:0]  SELECT_OFS  = 8'h00;
  localparam logic [7:0]  SYSCFG_OFS  = 8'h04;
  localparam logic [7:0]  TKCTRL_OFS  = 8'h08;
  localparam logic [7:0]  STATUS_OFS  = 8'h0c;
  localparam logic [7:0]  ROUTE_OFS   = 8'h10;

  localparam logic [4:0]  SELECT_RESET = 5'h05;
  localparam logic [4:0]  ALL_ENABLED  = 5'h1f;

  localparam int FIRST_CAN_BIT  = 0;
  localparam int SECOND_CAN_BIT = 1;
  localparam int SMALL_RAM_BIT  = 2;
  localparam int LARGE_RAM_BIT  = 3;
  localparam int TIMEKEEPER_BIT = 4;
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int OSC_CHOICE_BIT = 0;

  localparam logic [23:0] FIRST_CAN_LO  = 24'h00ef00;
  localparam logic [23:0] FIRST_CAN_HI  = 24'h00efff;
  localparam logic [23:0] SECOND_CAN_LO = 24'h00ee00;
  localparam logic [23:0] SECOND_CAN_HI = 24'h00eeff;
  localparam logic [23:0] TIMEKEEPER_LO = 24'h00ec00;
  localparam logic [23:0] TIMEKEEPER_HI = 24'h00ecff;
  localparam logic [23:0] SMALL_RAM_LO  = 24'h00e000;
  localparam logic [23:0] SMALL_RAM_HI  = 24'h00e7ff;
  localparam logic [23:0] LARGE_RAM_LO  = 24'h00c000;
  localparam logic [23:0] LARGE_RAM_HI  = 24'h00dfff;

  typedef struct packed {
    logic to_external;
    logic to_first_can;
    logic to_second_can;
    logic to_small_ram;
    logic to_large_ram;
    logic to_timekeeper;
    logic outside;
  } route_s;

  typedef struct packed {
    logic [4:0]  select;
    logic        global_en;
    logic        osc_choice;
    logic [1:0]  emu_sync;
    logic        wr_pend;
    logic [7:0]  wr_ofs;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        route_valid;
    route_s      route;
    route_s      last_route;
    logic [23:0] route_addr;
    logic        osc_run;
    logic [3:0]  gpio_release;
  } state_s;

endpackage : periph_select_pkg

// >>> periph_select_decode.sv
// ahb-lite register bank and address steering for the extension peripherals
module periph_select_decode (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output wire logic [31:0]               hrdata,
  output wire logic                      hreadyout,
  output wire logic                      hresp,
  input  wire logic                      cpu_req,
  input  wire logic [23:0]               cpu_addr,
  input  wire logic                      emulation_pin,
  input  wire logic                      powerdown_request,
  output wire logic                      route_valid,
  output wire periph_select_pkg::route_s route,
  output wire logic [23:0]               route_addr,
  output wire logic                      osc_run,
  output wire logic [3:0]                gpio_release
);
  import periph_select_pkg::*;

  state_s     st;
  state_s     next_st;
  logic [4:0] eff;
  logic       in_first_can;
  logic       in_second_can;
  logic       in_timekeeper;
  logic       in_small_ram;
  logic       in_large_ram;
  logic       addr_phase;
  route_s     dec;

  // emulation overrides the programmed value, not the stored one
  assign eff = st.emu_sync[1] ? ALL_ENABLED : st.select;

  assign in_first_can  = cpu_addr >= FIRST_CAN_LO && cpu_addr <= FIRST_CAN_HI;
  assign in_second_can = cpu_addr >= SECOND_CAN_LO && cpu_addr <= SECOND_CAN_HI;
  assign in_timekeeper = cpu_addr >= TIMEKEEPER_LO && cpu_addr <= TIMEKEEPER_HI;
  assign in_small_ram  = cpu_addr >= SMALL_RAM_LO && cpu_addr <= SMALL_RAM_HI;
  assign in_large_ram  = cpu_addr >= LARGE_RAM_LO && cpu_addr <= LARGE_RAM_HI;

  assign addr_phase = hsel && hready && htrans[1];

  assign hrdata       = st.hrdata;
  assign hreadyout    = st.hreadyout;
  assign hresp        = st.hresp;
  assign route_valid  = st.route_valid;
  assign route        = st.route;
  assign route_addr   = st.route_addr;
  assign osc_run      = st.osc_run;
  assign gpio_release = st.gpio_release;

  // a window whose owner is off but whose neighbour is on stays unserved
  always_comb begin
    dec = '0;
    if (in_timekeeper) begin
      if (eff[TIMEKEEPER_BIT]) begin
        dec.to_timekeeper = 1'b1;
      end else if (!eff[FIRST_CAN_BIT] && !eff[SECOND_CAN_BIT]) begin
        dec.to_external = 1'b1;
      end
    end else if (in_first_can) begin
      if (eff[FIRST_CAN_BIT]) begin
        dec.to_first_can = 1'b1;
      end else if (!eff[SECOND_CAN_BIT]) begin
        dec.to_external = 1'b1;
      end
    end else if (in_second_can) begin
      if (eff[SECOND_CAN_BIT]) begin
        dec.to_second_can = 1'b1;
      end else if (!eff[FIRST_CAN_BIT]) begin
        dec.to_external = 1'b1;
      end
    end else if (in_small_ram) begin
      dec.to_small_ram = eff[SMALL_RAM_BIT];
      dec.to_external  = !eff[SMALL_RAM_BIT];
    end else if (in_large_ram) begin
      dec.to_large_ram = eff[LARGE_RAM_BIT];
      dec.to_external  = !eff[LARGE_RAM_BIT];
    end else begin
      dec.outside = 1'b1;
    end
  end

  always_comb begin
    next_st          = st;
    next_st.emu_sync = {st.emu_sync[0], emulation_pin};

    // data phase of a write: hwdata stands now
    if (st.wr_pend) begin
      case (st.wr_ofs)
        SELECT_OFS: begin
          if (!st.global_en) begin
            next_st.select = hwdata[4:0];
          end
        end
        SYSCFG_OFS: begin
          // sticky: only reset unlocks the selection
          if (hwdata[GLOBAL_EN_BIT]) begin
            next_st.global_en = 1'b1;
          end
        end
        TKCTRL_OFS: begin
          next_st.osc_choice = hwdata[OSC_CHOICE_BIT];
        end
        default: begin
        end
      endcase
    end

    next_st.wr_pend = 1'b0;
    if (addr_phase) begin
      next_st.wr_pend = hwrite;
      next_st.wr_ofs  = haddr[7:0];
      // read from next_st so a write just finishing is already visible
      if (!hwrite) begin
        case (haddr[7:0])
          SELECT_OFS: next_st.hrdata = {27'h0, next_st.select};
          SYSCFG_OFS: next_st.hrdata = {31'h0, next_st.global_en};
          TKCTRL_OFS: next_st.hrdata = {31'h0, next_st.osc_choice};
          STATUS_OFS: next_st.hrdata = {24'h000000, st.osc_run, st.emu_sync[1],
                                        st.global_en, eff};
          ROUTE_OFS:  next_st.hrdata = {25'h0, st.last_route};
          default:    next_st.hrdata = 32'h00000000;
        endcase
      end
    end
    next_st.hreadyout = 1'b1;
    next_st.hresp     = 1'b0;

    next_st.route_valid = cpu_req;
    next_st.route       = cpu_req ? dec : '0;
    next_st.route_addr  = cpu_addr;
    if (cpu_req) begin
      next_st.last_route = dec;
    end

    // oscillator stops only inside power-down
    next_st.osc_run = !(powerdown_request &&
                        (!eff[TIMEKEEPER_BIT] || st.osc_choice));

    next_st.gpio_release[0] = !eff[SECOND_CAN_BIT];
    next_st.gpio_release[3] = !eff[SECOND_CAN_BIT];
    next_st.gpio_release[1] = !eff[FIRST_CAN_BIT];
    next_st.gpio_release[2] = !eff[FIRST_CAN_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st              <= '0;
      st.select       <= SELECT_RESET;
      st.hreadyout    <= 1'b1;
      st.osc_run      <= 1'b1;
      st.gpio_release <= {~SELECT_RESET[SECOND_CAN_BIT], ~SELECT_RESET[FIRST_CAN_BIT],
                          ~SELECT_RESET[FIRST_CAN_BIT], ~SELECT_RESET[SECOND_CAN_BIT]};
    end else begin
      st <= next_st;
    end
  end

  property p_timekeeper_route;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_timekeeper && eff[TIMEKEEPER_BIT] |=> route_valid && route.to_timekeeper;
  endproperty
  a_timekeeper_route: assert property (p_timekeeper_route)
    else $error("timekeeper access not routed on chip");

  property p_can_external;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && (in_first_can || in_second_can) && eff[1:0] == 2'h0
      |=> route.to_external && !route.to_first_can && !route.to_second_can;
  endproperty
  a_can_external: assert property (p_can_external)
    else $error("can window not sent external with both cans off");

  property p_second_pins;
    @(posedge hclk) disable iff (!hresetn)
      !eff[SECOND_CAN_BIT] |=> gpio_release[0] && gpio_release[3];
  endproperty
  a_second_pins: assert property (p_second_pins)
    else $error("second can pins not released");

  property p_first_pins;
    @(posedge hclk) disable iff (!hresetn)
      eff[FIRST_CAN_BIT] |=> !gpio_release[1] && !gpio_release[2];
  endproperty
  a_first_pins: assert property (p_first_pins)
    else $error("first can pins released while it is enabled");

  property p_reset_select;
    @(posedge hclk) disable iff (!hresetn)
      $rose(hresetn) |-> st.select == SELECT_RESET && !st.global_en;
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("selection wrong after reset");

  property p_lock_holds;
    @(posedge hclk) disable iff (!hresetn)
      st.global_en |=> st.global_en && $stable(st.select);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("selection changed after lock");

  property p_locked_write;
    @(posedge hclk) disable iff (!hresetn)
      st.global_en && st.wr_pend && st.wr_ofs == SELECT_OFS
      |=> st.select == $past(st.select) && hresp == 1'b0;
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("locked selection write took effect or errored");

  property p_emulation;
    @(posedge hclk) disable iff (!hresetn)
      st.emu_sync[1] && cpu_req && in_large_ram |=> route.to_large_ram ##1 !gpio_release[1];
  endproperty
  a_emulation: assert property (p_emulation)
    else $error("emulation did not enable every peripheral");

  property p_osc_off;
    @(posedge hclk) disable iff (!hresetn)
      powerdown_request && !eff[TIMEKEEPER_BIT] |=> !osc_run;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator kept running in power-down");

  property p_osc_choice;
    @(posedge hclk) disable iff (!hresetn)
      powerdown_request && eff[TIMEKEEPER_BIT] |=> osc_run == !$past(st.osc_choice);
  endproperty
  a_osc_choice: assert property (p_osc_choice)
    else $error("oscillator ignored power-down choice");

  property p_small_ram;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_small_ram |=> route.to_external == !$past(eff[SMALL_RAM_BIT])
                                  && route.to_small_ram == $past(eff[SMALL_RAM_BIT]);
  endproperty
  a_small_ram: assert property (p_small_ram)
    else $error("small ram window misrouted");

  property p_large_ram;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_large_ram |=> route.to_external == !$past(eff[LARGE_RAM_BIT])
                                  && route.to_large_ram == $past(eff[LARGE_RAM_BIT]);
  endproperty
  a_large_ram: assert property (p_large_ram)
    else $error("large ram window misrouted");

  property p_can_owner;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_second_can && eff[SECOND_CAN_BIT]
      |=> route.to_second_can && !route.to_external;
  endproperty
  a_can_owner: assert property (p_can_owner)
    else $error("second can window misrouted");

  property p_timekeeper_hold;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_timekeeper && !eff[TIMEKEEPER_BIT] && eff[1:0] != 2'h0
      |=> !route.to_external && !route.to_timekeeper;
  endproperty
  a_timekeeper_hold: assert property (p_timekeeper_hold)
    else $error("timekeeper window sent external with a can on");

  property p_first_owner;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req && in_first_can && eff[FIRST_CAN_BIT]
      |=> route.to_first_can && !route.to_external;
  endproperty
  a_first_owner: assert property (p_first_owner)
    else $error("first can window misrouted");

  property p_second_held;
    @(posedge hclk) disable iff (!hresetn)
      eff[SECOND_CAN_BIT] |=> !gpio_release[0] && !gpio_release[3];
  endproperty
  a_second_held: assert property (p_second_held)
    else $error("second can pins released while it is enabled");

  property p_first_released;
    @(posedge hclk) disable iff (!hresetn)
      !eff[FIRST_CAN_BIT] |=> gpio_release[1] && gpio_release[2];
  endproperty
  a_first_released: assert property (p_first_released)
    else $error("first can pins not released");

  property p_osc_awake;
    @(posedge hclk) disable iff (!hresetn)
      !powerdown_request |=> osc_run;
  endproperty
  a_osc_awake: assert property (p_osc_awake)
    else $error("oscillator stopped outside power-down");

  property p_select_write;
    @(posedge hclk) disable iff (!hresetn)
      !st.global_en && st.wr_pend && st.wr_ofs == SELECT_OFS
      |=> st.select == $past(hwdata[4:0]);
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("unlocked selection write lost");

  property p_route_echo;
    @(posedge hclk) disable iff (!hresetn)
      cpu_req |=> route_valid && route_addr == $past(cpu_addr);
  endproperty
  a_route_echo: assert property (p_route_echo)
    else $error("external address not passed on");

endmodule : periph_select_decode

// >>> cpu_steer_model.sv
// cpu-side requester that asks the steering logic for one lookup per call
module cpu_steer_model (
  input  wire logic        hclk,
  output logic             cpu_req,
  output logic [23:0]      cpu_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cpu_req  = 1'b0;
    cpu_addr = 24'h0;
  end

  // address inverted on release so a stale value can never pass for a match
  task automatic lookup(input logic [23:0] a);
    @(posedge hclk);
    cpu_req  <= 1'b1;
    cpu_addr <= a;
    @(posedge hclk);
    cpu_req  <= 1'b0;
    cpu_addr <= ~a;
  endtask : lookup
endmodule : cpu_steer_model

// >>> testbench.sv
// self-checking bench for the peripheral select decode
module testbench;
  import periph_select_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, emu, pdn, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, cpu_req, route_valid, osc_run;
  logic [23:0] cpu_addr, route_addr;
  logic [3:0]  gpio_release;
  route_s      route;
  int          bad_count, num_checks, cycles;
  logic [30:0] rq[$];
  logic [31:0] dq[$];
  logic [23:0] bases[6] = '{24'h00ef00, 24'h00ee00, 24'h00ec00, 24'h00e000,
                            24'h00c000, 24'h008000};
  logic [4:0]  sels[6] = '{5'h05, 5'h00, 5'h1f, 5'h10, 5'h02, 5'h09};

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  periph_select_decode i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .emulation_pin(emu), .powerdown_request(pdn),
    .route_valid(route_valid), .route(route), .route_addr(route_addr),
    .osc_run(osc_run), .gpio_release(gpio_release));

  cpu_steer_model i_cpu (.hclk(hclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr));

  task automatic note(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : note

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    note(g === e && hresp === 1'b0, "read data");
  endtask : chk_word

  task automatic chk_route(input logic [30:0] e);
    note(route === e[6:0] && route_addr === e[30:7], "route");
  endtask : chk_route

  task automatic chk_pin(input logic [4:0] e);
    note({osc_run, gpio_release} === e, "osc or gpio");
  endtask : chk_pin

  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // address phase held until hready, then data phase until hready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    dq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  function automatic route_s exp_route(input logic [4:0] s, input logic [23:0] a);
    route_s r;
    r = '0;
    if (a >= FIRST_CAN_LO && a <= FIRST_CAN_HI) begin
      r.to_first_can = s[0];
      r.to_external  = !s[0] && !s[1];
    end else if (a >= SECOND_CAN_LO && a <= SECOND_CAN_HI) begin
      r.to_second_can = s[1];
      r.to_external   = !s[0] && !s[1];
    end else if (a >= TIMEKEEPER_LO && a <= TIMEKEEPER_HI) begin
      r.to_timekeeper = s[4];
      r.to_external   = !s[4] && !s[0] && !s[1];
    end else if (a >= SMALL_RAM_LO && a <= SMALL_RAM_HI) begin
      r.to_small_ram = s[2];
      r.to_external  = !s[2];
    end else if (a >= LARGE_RAM_LO && a <= LARGE_RAM_HI) begin
      r.to_large_ram = s[3];
      r.to_external  = !s[3];
    end else begin
      r.outside = 1'b1;
    end
    return r;
  endfunction : exp_route

  task automatic sweep(input logic [4:0] s);
    logic [23:0] a;
    foreach (bases[j]) begin
      a = bases[j] | 24'($urandom_range(255));
      rq.push_back({a, exp_route(s, a)});
      i_cpu.lookup(a);
    end
  endtask : sweep

  always @(posedge hclk) begin
    if (hresetn === 1'b1 && route_valid === 1'b1) begin
      if (rq.size() == 0) note(1'b0, "route without request");
      else chk_route(rq.pop_front());
    end
    if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
      if (dq.size() == 0) note(1'b0, "read without note");
      else chk_word(dq.pop_front(), hrdata);
    end
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    emu = 1'b0;
    pdn = 1'b0;
    rd_dp = 1'b0;
    void'($urandom(20));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (sels[i]) begin
      if (i > 0) bus(1'b1, SELECT_OFS, {27'h0, sels[i]});
      rd(SELECT_OFS, {27'h0, sels[i]});
      sweep(sels[i]);
      repeat (2) @(posedge hclk);
      chk_pin({1'b1, ~sels[i][1], ~sels[i][0], ~sels[i][0], ~sels[i][1]});
      for (int c = 0; c < 2; c++) begin
        bus(1'b1, TKCTRL_OFS, 32'(c));
        pdn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_pin({sels[i][4] && c == 0, ~sels[i][1], ~sels[i][0], ~sels[i][0],
                 ~sels[i][1]});
        pdn <= 1'b0;
      end
    end
    // emulation forces enables but leaves the stored selection readable
    bus(1'b1, SELECT_OFS, 32'h0);
    emu <= 1'b1;
    repeat (4) @(posedge hclk);
    sweep(ALL_ENABLED);
    rd(STATUS_OFS, 32'h000000df);
    rd(SELECT_OFS, 32'h0);
    emu <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b1, SYSCFG_OFS, 32'h1);
    bus(1'b1, SELECT_OFS, 32'h1f);
    rd(SELECT_OFS, 32'h0);
    sweep(5'h00);
    rd(STATUS_OFS, 32'h000000a0);
    rd(ROUTE_OFS, 32'h00000001);
    rd(8'h20, 32'h0);
    repeat (4) @(posedge hclk);
    // a second reset must clear the sticky lock
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk_pin(5'h19);
    hresetn <= 1'b1;
    rd(SELECT_OFS, 32'h00000005);
    rd(SYSCFG_OFS, 32'h0);
    bus(1'b1, SELECT_OFS, 32'h00000003);
    rd(SELECT_OFS, 32'h00000003);
    sweep(5'h03);
    repeat (4) @(posedge hclk);
    note(rq.size() == 0 && dq.size() == 0, "missing results");
    finish_test();
  end
endmodule : testbench
